// [hdl/lim_pkg.sv]
package lim_pkg;
    // Clock and timing.
    localparam int CLK_NS = 40;
    localparam int E1_PW_NS = 244;
    localparam int DSX_PW_NS = 350;
    localparam int NI_PW_NS = 324;
    localparam int TX_STALL_NS = 2000;
    localparam int DPM_IDLE_NS = 10000;
    localparam logic [3:0] E1_PW_CYC = 4'(E1_PW_NS / CLK_NS);
    localparam logic [3:0] DSX_PW_CYC = 4'(DSX_PW_NS / CLK_NS);
    localparam logic [3:0] NI_PW_CYC = 4'(NI_PW_NS / CLK_NS);
    localparam logic [5:0] TX_STALL_CYC = 6'((TX_STALL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] DPM_IDLE_CYC = 8'((DPM_IDLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [6:0] AIS_MARKS = 7'h40;
    localparam logic [1:0] MODE_CAP_DLY = 2'h2;
    localparam logic [3:0] SER_DATA_BITS = 4'h8;

    // Positions in the synchronised pin vector.
    localparam int SYNC_W = 15;
    localparam int SI_TXCLK = 0;
    localparam int SI_P3 = 1;
    localparam int SI_P4 = 2;
    localparam int SI_RCLK = 3;
    localparam int SI_RXP = 4;
    localparam int SI_RXN = 5;
    localparam int SI_P17 = 6;
    localparam int SI_P18 = 7;
    localparam int SI_P23 = 8;
    localparam int SI_P24 = 9;
    localparam int SI_P25 = 10;
    localparam int SI_P26 = 11;
    localparam int SI_P27 = 12;
    localparam int SI_MLO = 13;
    localparam int SI_MHI = 14;

    // Configuration word: line shape in the low bits, then the loops.
    localparam int CFG_W = 5;
    localparam int CFG_REMOTE_LOOP_SEL = 3;
    localparam int CFG_LOCAL_LOOP_SEL = 4;
    localparam logic [2:0] SHAPE_E1 = 3'h0;
    localparam logic [2:0] SHAPE_NI_A = 3'h1;
    localparam logic [2:0] SHAPE_NI_B = 3'h2;

    // Register map and status events.
    localparam logic [31:0] OFS_STATUS = 32'h0000_0000;
    localparam logic [31:0] OFS_MASK = 32'h0000_0004;
    localparam logic [31:0] OFS_MODE = 32'h0000_0008;
    localparam logic [31:0] OFS_CFG = 32'h0000_000c;
    localparam int ST_W = 4;
    localparam int EV_STALL = 0;
    localparam int EV_BPV = 1;
    localparam int EV_AIS = 2;
    localparam int EV_DPM = 3;

    typedef enum logic [2:0] {MODE_HW = 3'b001, MODE_EXT = 3'b010, MODE_HOST = 3'b100} lim_mode_t;
    typedef enum logic [3:0] {
        SER_IDLE = 4'b0001, SER_CMD = 4'b0010, SER_WDATA = 4'b0100, SER_RDATA = 4'b1000
    } lim_ser_t;
endpackage

// [hdl/lim_mode_pin_ctrl.sv]
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - Mode pin comparators decode hardware, extended hardware or host mode.
// - Hardware modes take configuration from line-shape and loop select pins.
// - Extended mode latches shared control inputs on the active-low parallel strobe.
// - Host mode takes shape and loop settings only from the serial port, which also reads status.
// - Host mode turns select pins into alert, serial in/out, select, clock.
// - Extended mode turns data pins into single-rail data, coding and alarms.
// - Only extended mode codes the line itself; others pass dual-rail data.
// - All-ones alarm only in extended mode; driver monitor otherwise.
// - A stopped transmit clock forces both line outputs low.
// - Transmit data is sampled on the falling transmit clock edge.
// - Receive output edge follows mode and edge select.
// - Line pulse width is timed internally, not by transmit clock duty.
// - Recovered clock may run 62.5 or 37.5 percent high at limits.
// - In host mode edge select also sets serial output timing.
// - Line shape zero selects E1; others select T1 widths.
module lim_mode_pin_ctrl
    import lim_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    // Mode comparators and clocks from the pins
    input wire logic mode_above_low,
    input wire logic mode_above_high,
    input wire logic tx_clk,
    input wire logic rx_clk,
    input wire logic rx_rec_pos,
    input wire logic rx_rec_neg,
    input wire logic edge_select,
    // Multi-function pins
    input wire logic pin3_in,
    input wire logic pin4_in,
    input wire logic pin17_in,
    input wire logic pin18_in,
    input wire logic pin23_in,
    input wire logic pin24_in,
    input wire logic pin25_in,
    input wire logic pin26_in,
    input wire logic pin27_in,
    output logic pin6_out,
    output logic pin7_out,
    output logic pin11_out,
    output logic pin23_out,
    output logic pin23_oe_n,
    output logic pin25_out,
    output logic pin25_oe_n,
    // Line driver and loop controls
    output logic line_out_pos,
    output logic line_out_neg,
    output logic remote_loop_en,
    output logic local_loop_en
);
    logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
    lim_mode_t mode_q;
    logic [1:0] cap_cnt_q;
    logic mode_done_q, tx_pol_q, tx_mark_q, tx_stalled_q, rx_last_q, dpm_q, ais_q;
    logic [3:0] pw_cnt_q;
    logic [5:0] stall_cnt_q;
    logic [7:0] dpm_cnt_q;
    logic [6:0] ais_cnt_q;
    logic [CFG_W-1:0] cfg_q, cfg_ext_q, cfg_host_q, pin_cfg;
    lim_ser_t ser_q;
    logic [7:0] ser_sh_q;
    logic [3:0] ser_cnt_q;
    logic [ST_W-1:0] status_q, mask_q, ev;
    logic [31:0] addr_q;
    logic wr_q;
    logic tx_fall, tx_edge, rx_rise, rx_fall, rx_launch, sck_rise, sck_fall, cs_n, mark_in;

    function automatic logic rose(input int i);
        return s2_q[i] && !s3_q[i];
    endfunction

    function automatic logic fell(input int i);
        return !s2_q[i] && s3_q[i];
    endfunction

    function automatic logic [3:0] pulse_cyc(input logic [2:0] shape);
        if (shape == SHAPE_E1)
            return E1_PW_CYC;
        else if (shape == SHAPE_NI_A || shape == SHAPE_NI_B)
            return NI_PW_CYC;
        return DSX_PW_CYC;
    endfunction

    // Every pin except edge_select crosses two flops before use; the third flop only feeds edge finders.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= {mode_above_high, mode_above_low, pin27_in, pin26_in, pin25_in, pin24_in,
                     pin23_in, pin18_in, pin17_in, rx_rec_neg, rx_rec_pos, rx_clk, pin4_in,
                     pin3_in, tx_clk};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign tx_fall = fell(SI_TXCLK);
    assign tx_edge = tx_fall || rose(SI_TXCLK);
    // Both edges are found separately, so a skewed high phase is tolerated.
    assign rx_rise = rose(SI_RCLK);
    assign rx_fall = fell(SI_RCLK);
    assign rx_launch = (mode_q == MODE_EXT || (mode_q == MODE_HOST && edge_select)) ? rx_rise
                                                                                  : rx_fall;
    assign sck_rise = rose(SI_P27);
    assign sck_fall = fell(SI_P27);
    assign cs_n = s2_q[SI_P26];
    assign mark_in = s2_q[SI_P3];
    assign pin_cfg = {s2_q[SI_P27], s2_q[SI_P26], s2_q[SI_P25], s2_q[SI_P24], s2_q[SI_P23]};

    // Mode is taken once, after the synchroniser has filled, and then held.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q <= MODE_HW;
            cap_cnt_q <= '0;
            mode_done_q <= 1'b0;
        end
        else if (!mode_done_q)
        begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == MODE_CAP_DLY)
            begin
                mode_done_q <= 1'b1;
                if (!s2_q[SI_MLO])
                    mode_q <= MODE_HW;
                else if (s2_q[SI_MHI])
                    mode_q <= MODE_HOST;
                else
                    mode_q <= MODE_EXT;
            end
        end
    end

    // Configuration source per mode.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cfg_ext_q <= '0;
            cfg_q <= '0;
        end
        else
        begin
            if (mode_q == MODE_EXT && rose(SI_P18))
                cfg_ext_q <= pin_cfg;
            case (mode_q)
                MODE_HW: cfg_q <= pin_cfg;
                MODE_EXT: cfg_q <= cfg_ext_q;
                MODE_HOST: cfg_q <= cfg_host_q;
                default: cfg_q <= '0;
            endcase
        end
    end

    // Transmit side: sample on the falling clock edge, time the pulse on hclk.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pw_cnt_q <= '0;
            tx_pol_q <= 1'b0;
            tx_mark_q <= 1'b0;
            stall_cnt_q <= '0;
            tx_stalled_q <= 1'b1;
            line_out_pos <= 1'b0;
            line_out_neg <= 1'b0;
        end
        else
        begin
            if (tx_edge)
                stall_cnt_q <= '0;
            else if (stall_cnt_q != TX_STALL_CYC)
                stall_cnt_q <= stall_cnt_q + 6'h1;
            tx_stalled_q <= !tx_edge && stall_cnt_q == TX_STALL_CYC;
            if (tx_fall && mode_q == MODE_EXT && mark_in)
            begin
                pw_cnt_q <= pulse_cyc(cfg_q[2:0]);
                tx_mark_q <= tx_pol_q;
                tx_pol_q <= !tx_pol_q;
            end
            else if (tx_fall && mode_q != MODE_EXT && (mark_in || s2_q[SI_P4]))
            begin
                pw_cnt_q <= pulse_cyc(cfg_q[2:0]);
                tx_mark_q <= !mark_in;
            end
            else if (pw_cnt_q != '0)
                pw_cnt_q <= pw_cnt_q - 4'h1;
            line_out_pos <= pw_cnt_q != '0 && !tx_mark_q && !tx_stalled_q;
            line_out_neg <= pw_cnt_q != '0 && tx_mark_q && !tx_stalled_q;
        end
    end

    // Receive side, driver monitor and all-ones detection.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin6_out <= 1'b0;
            pin7_out <= 1'b0;
            pin11_out <= 1'b0;
            rx_last_q <= 1'b0;
            ais_cnt_q <= '0;
            ais_q <= 1'b0;
            dpm_cnt_q <= '0;
            dpm_q <= 1'b0;
        end
        else
        begin
            if (rose(SI_P17) || rose(SI_P18))
                dpm_cnt_q <= '0;
            else if (dpm_cnt_q != DPM_IDLE_CYC)
                dpm_cnt_q <= dpm_cnt_q + 8'h1;
            dpm_q <= mode_q != MODE_EXT && dpm_cnt_q == DPM_IDLE_CYC;
            if (rx_launch && mode_q == MODE_EXT)
            begin
                pin7_out <= s2_q[SI_RXP] || s2_q[SI_RXN];
                pin6_out <= (s2_q[SI_RXP] && rx_last_q) || (s2_q[SI_RXN] && !rx_last_q);
                if (s2_q[SI_RXP] || s2_q[SI_RXN])
                    rx_last_q <= s2_q[SI_RXP];
                if (!(s2_q[SI_RXP] || s2_q[SI_RXN]))
                    ais_cnt_q <= '0;
                else if (ais_cnt_q != AIS_MARKS)
                    ais_cnt_q <= ais_cnt_q + 7'h1;
                ais_q <= ais_cnt_q == AIS_MARKS;
            end
            else if (rx_launch)
            begin
                pin7_out <= s2_q[SI_RXP];
                pin6_out <= s2_q[SI_RXN];
            end
            pin11_out <= (mode_q == MODE_EXT) ? ais_q : dpm_q;
        end
    end

    // Host serial port: command bit (1 reads status), then eight data bits.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ser_q <= SER_IDLE;
            ser_sh_q <= '0;
            ser_cnt_q <= '0;
            cfg_host_q <= '0;
            pin25_out <= 1'b0;
            pin25_oe_n <= 1'b1;
            pin23_out <= 1'b0;
            pin23_oe_n <= 1'b1;
        end
        else
        begin
            pin23_oe_n <= !(mode_q == MODE_HOST && irq);
            pin25_oe_n <= !(mode_q == MODE_HOST && !cs_n && ser_q == SER_RDATA);
            if (cs_n || mode_q != MODE_HOST)
                ser_q <= SER_CMD;
            else
            begin
                case (ser_q)
                    SER_CMD:
                        if (sck_rise && s2_q[SI_P24])
                        begin
                            ser_q <= SER_RDATA;
                            if (edge_select)
                                ser_sh_q <= 8'(status_q);
                            else
                            begin
                                pin25_out <= status_q[0];
                                ser_sh_q <= 8'(status_q >> 1);
                            end
                        end
                        else if (sck_rise)
                        begin
                            ser_q <= SER_WDATA;
                            ser_cnt_q <= '0;
                        end
                    SER_WDATA:
                        if (sck_rise && ser_cnt_q != SER_DATA_BITS)
                        begin
                            ser_sh_q <= {s2_q[SI_P24], ser_sh_q[7:1]};
                            ser_cnt_q <= ser_cnt_q + 4'h1;
                            if (ser_cnt_q == SER_DATA_BITS - 4'h1)
                                cfg_host_q <= {s2_q[SI_P24], ser_sh_q[7:9-CFG_W]};
                        end
                    SER_RDATA:
                        if (edge_select ? sck_fall : sck_rise)
                        begin
                            pin25_out <= ser_sh_q[0];
                            ser_sh_q <= {1'b0, ser_sh_q[7:1]};
                        end
                    default: ser_q <= SER_IDLE;
                endcase
            end
        end
    end

    assign remote_loop_en = cfg_q[CFG_REMOTE_LOOP_SEL];
    assign local_loop_en = cfg_q[CFG_LOCAL_LOOP_SEL];
    assign ev = {dpm_q, ais_q, pin6_out && mode_q == MODE_EXT, tx_stalled_q};

    // AHB-Lite slave with zero wait states; status bits are write-one-to-clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_q <= '0;
            wr_q <= 1'b0;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            status_q <= '0;
            mask_q <= '0;
            irq <= 1'b0;
        end
        else
        begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready)
            begin
                addr_q <= haddr;
                case (haddr)
                    OFS_STATUS: hrdata <= 32'(status_q);
                    OFS_MASK: hrdata <= 32'(mask_q);
                    OFS_MODE: hrdata <= 32'({tx_stalled_q, mode_q});
                    OFS_CFG: hrdata <= 32'(cfg_q);
                    default: hrdata <= '0;
                endcase
            end
            if (wr_q && addr_q == OFS_MASK)
                mask_q <= hwdata[ST_W-1:0];
            if (wr_q && addr_q == OFS_STATUS)
                status_q <= (status_q & ~hwdata[ST_W-1:0]) | ev;
            else
                status_q <= status_q | ev;
            irq <= (status_q & mask_q) != '0;
        end
    end

    p_stall_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_stalled_q |=> !line_out_pos && !line_out_neg) else $error("line driven while stalled");
    p_stall_det: assert property (@(posedge hclk) disable iff (!hresetn)
        stall_cnt_q == TX_STALL_CYC && !tx_edge |=> tx_stalled_q) else $error("stall missed");
    p_mode_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_done_q |=> $stable(mode_q)) else $error("mode changed");
    p_sdo_hiz: assert property (@(posedge hclk) disable iff (!hresetn)
        cs_n |=> pin25_oe_n) else $error("serial out driven while deselected");
    p_pulse_e1: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_fall && mode_q == MODE_HW && mark_in && cfg_q[2:0] == SHAPE_E1 && stall_cnt_q == '0
        |-> ##2 line_out_pos[*6] ##1 !line_out_pos) else $error("E1 width wrong");
    p_ami_alt: assert property (@(posedge hclk) disable iff (!hresetn)
        tx_fall && mode_q == MODE_EXT && mark_in |=> tx_pol_q != $past(tx_pol_q))
        else $error("AMI polarity kept");
    p_alert: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_q == MODE_HOST && irq |=> !pin23_oe_n && !pin23_out) else $error("alert idle");
    p_strobe: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_q == MODE_EXT && rose(SI_P18) |=> cfg_ext_q == $past(pin_cfg))
        else $error("strobe latch missed");
    p_rx_hw: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_q == MODE_HW && rx_fall |=> pin7_out == $past(s2_q[SI_RXP]))
        else $error("receive edge wrong");
    p_pin11: assert property (@(posedge hclk) disable iff (!hresetn)
        mode_q != MODE_EXT |=> !ais_q || pin11_out == $past(dpm_q))
        else $error("alarm outside extended mode");
    c_stall: cover property (@(posedge hclk) disable iff (!hresetn) tx_stalled_q ##1 tx_edge);
    c_read: cover property (@(posedge hclk) disable iff (!hresetn) !pin25_oe_n ##1 cs_n);
    c_strobe: cover property (@(posedge hclk) disable iff (!hresetn) mode_q == MODE_EXT && rose(SI_P18));
endmodule // lim_mode_pin_ctrl

// [test/lim_framer_model.sv]
`timescale 1ns/1ns
// Framer and control processor beside the line interface. Link clocks stand still between bursts.
module lim_framer_model (
    // Bench clock and serial readback
    input wire logic hclk,
    input wire logic serial_out,
    // Transmit side
    output logic tx_clk,
    output logic pin3_in,
    output logic pin4_in,
    // Receive side
    output logic rx_clk,
    output logic rx_rec_pos,
    output logic rx_rec_neg,
    // Control pins
    output logic pin17_in,
    output logic pin18_in,
    output logic [4:0] ctl_pins
);
    initial
    begin
        tx_clk = 1'b0;
        rx_clk = 1'b0;
        pin3_in = 1'b0;
        pin4_in = 1'b0;
        rx_rec_pos = 1'b0;
        rx_rec_neg = 1'b0;
        pin17_in = 1'b0;
        pin18_in = 1'b1;
        ctl_pins = 5'h08;
    end

    // Marks change only while the clock is low, well clear of the falling edge.
    task automatic tx_burst(input logic p, input logic n, input int cyc, input int hi, input int per);
        pin3_in = p;
        pin4_in = n;
        #13;
        repeat (cyc)
        begin
            tx_clk = 1'b1;
            #hi;
            tx_clk = 1'b0;
            #(per - hi);
        end
        pin3_in = ~p;
        pin4_in = ~n;
    endtask

    task automatic rx_burst(input logic p, input logic n, input int cyc);
        rx_rec_pos = p;
        rx_rec_neg = n;
        #13;
        repeat (cyc)
        begin
            rx_clk = 1'b1;
            #160;
            rx_clk = 1'b0;
            #160;
        end
    endtask

    task automatic set_ctl(input logic [4:0] v);
        @(posedge hclk);
        ctl_pins <= v;
    endtask

    task automatic strobe(input logic [4:0] v);
        set_ctl(v);
        repeat (3) @(posedge hclk);
        pin18_in <= 1'b0;
        repeat (8) @(posedge hclk);
        pin18_in <= 1'b1;
        repeat (4) @(posedge hclk);
    endtask

    // Serial clock phases of 280 ns or more keep above the minimum low and high times.
    task automatic serial(input logic rd, input logic [7:0] wb, output logic [7:0] rb);
        rb = 8'h00;
        @(posedge hclk);
        ctl_pins[3] <= 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            repeat (7) @(posedge hclk);
            ctl_pins[1] <= (i == 0) ? rd : wb[3'(i - 1)];
            repeat (7) @(posedge hclk);
            ctl_pins[4] <= 1'b1;
            repeat (7) @(posedge hclk);
            ctl_pins[4] <= 1'b0;
            if (i < 8)
                rb[i] = serial_out;
        end
        repeat (7) @(posedge hclk);
        ctl_pins[3] <= 1'b1;
        ctl_pins[1] <= ~ctl_pins[1];
        repeat (4) @(posedge hclk);
    endtask
endmodule // lim_framer_model

// [test/lim_mode_pin_ctrl_bench.sv]
`timescale 1ns/1ns
module lim_mode_pin_ctrl_bench
    import lim_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic mode_above_low, mode_above_high, edge_select, host;
    logic tx_clk, rx_clk, rx_rec_pos, rx_rec_neg, pin3_in, pin4_in, pin17_in, pin18_in;
    logic pin23_in, pin24_in, pin25_in, pin26_in, pin27_in;
    logic pin6_out, pin7_out, pin11_out, pin23_out, pin23_oe_n, pin25_out, pin25_oe_n;
    logic line_out_pos, line_out_neg, remote_loop_en, local_loop_en;
    logic [4:0] ctl_pins;
    int n_mismatch = 0;
    int checks_done = 0;
    int run [2] = '{0, 0};
    int wid [2] = '{0, 0};
    int np [2] = '{0, 0};
    int oe_cnt = 0;

    assign hready = hreadyout;
    // The alert line floats high; a released serial output reads as the inverse of its last value.
    assign pin23_in = host ? (pin23_oe_n ? 1'b1 : pin23_out) : ctl_pins[0];
    assign pin24_in = ctl_pins[1];
    assign pin25_in = host ? (pin25_oe_n ? ~pin25_out : pin25_out) : ctl_pins[2];
    assign pin26_in = ctl_pins[3];
    assign pin27_in = ctl_pins[4];

    lim_mode_pin_ctrl uut (.*);
    lim_framer_model fr (.*, .serial_out(pin25_in));

    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    always @(negedge hclk)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if (((k == 0) ? line_out_pos : line_out_neg) === 1'b1)
            begin
                if (run[k] == 0)
                    np[k] <= np[k] + 1;
                run[k] <= run[k] + 1;
            end
            else
            begin
                if (run[k] != 0)
                    wid[k] <= run[k];
                run[k] <= 0;
            end
        end
        if (pin25_oe_n === 1'b0)
            oe_cnt <= oe_cnt + 1;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(negedge hclk); while (hready !== 1'b1);
        @(posedge hclk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(negedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge hclk);
    endtask

    task automatic do_reset(input logic lo, input logic hi);
        @(posedge hclk);
        hresetn <= 1'b0;
        mode_above_low <= lo;
        mode_above_high <= hi;
        host <= lo & hi;
        repeat (15) @(posedge hclk);
        @(negedge hclk);
        chk({26'h0, hreadyout, hresp, pin23_oe_n, pin25_oe_n, line_out_pos, line_out_neg}, 32'h2c);
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask

    task automatic t_hw;
        logic [31:0] rd;
        do_reset(1'b0, 1'b0);
        fr.set_ctl(5'h0d);
        repeat (6) @(posedge hclk);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        chk(rd & 32'h7, 32'(MODE_HW));
        ahb(1'b0, OFS_CFG, 32'h0, rd);
        chk(rd, 32'h0d);
        chk(32'(remote_loop_en), 32'h1);
        ahb(1'b1, OFS_MODE, 32'hff, rd);
        mode_above_low <= 1'b1;
        mode_above_high <= 1'b1;
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        chk(rd & 32'h7, 32'(MODE_HW));
        ahb(1'b0, 32'h40, 32'h0, rd);
        chk(rd, 32'h0);
    endtask

    task automatic t_tx;
        logic [31:0] rd;
        int n0;
        n0 = np[1];
        fr.set_ctl(5'h00);
        fr.tx_burst(1'b1, 1'b0, 6, 160, 320);
        repeat (12) @(posedge hclk);
        chk(32'(wid[0]), 32'(E1_PW_CYC));
        fr.tx_burst(1'b0, 1'b1, 6, 80, 320);
        repeat (12) @(posedge hclk);
        chk(32'(wid[1]), 32'(E1_PW_CYC));
        chk(32'(np[1] - n0), 32'h6);
        fr.set_ctl(5'h01);
        fr.tx_burst(1'b1, 1'b0, 4, 240, 480);
        repeat (14) @(posedge hclk);
        chk(32'(wid[0]), 32'(NI_PW_CYC));
        repeat (60) @(negedge hclk);
        chk({30'h0, line_out_pos, line_out_neg}, 32'h0);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        chk(rd >> 3, 32'h1);
    endtask

    task automatic t_irq;
        logic [31:0] rd;
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        chk(rd & 32'h1, 32'h1);
        chk(32'(irq), 32'h0);
        ahb(1'b1, OFS_MASK, 32'h1, rd);
        ahb(1'b0, OFS_MASK, 32'h0, rd);
        chk(rd, 32'h1);
        chk(32'(irq), 32'h1);
        fork
            fr.tx_burst(1'b0, 1'b0, 30, 160, 320);
        join_none
        repeat (20) @(posedge hclk);
        ahb(1'b1, OFS_STATUS, 32'h1, rd);
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        chk(rd & 32'h1, 32'h0);
        @(negedge hclk);
        chk(32'(irq), 32'h0);
        wait fork;
        repeat (60) @(negedge hclk);
        chk(32'(irq), 32'h1);
        ahb(1'b1, OFS_MASK, 32'h0, rd);
        repeat (2) @(negedge hclk);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_rx;
        fr.rx_burst(1'b1, 1'b0, 4);
        repeat (4) @(negedge hclk);
        chk({30'h0, pin7_out, pin6_out}, 32'h2);
        fr.rx_burst(1'b0, 1'b1, 4);
        repeat (4) @(negedge hclk);
        chk({30'h0, pin7_out, pin6_out}, 32'h1);
    endtask

    task automatic t_ext;
        logic [31:0] rd;
        int p0;
        int n0;
        do_reset(1'b1, 1'b0);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        chk(rd & 32'h7, 32'(MODE_EXT));
        fr.strobe(5'h16);
        ahb(1'b0, OFS_CFG, 32'h0, rd);
        chk(rd, 32'h16);
        chk(32'(local_loop_en), 32'h1);
        fr.set_ctl(5'h09);
        repeat (6) @(posedge hclk);
        ahb(1'b0, OFS_CFG, 32'h0, rd);
        chk(rd, 32'h16);
        p0 = np[0];
        n0 = np[1];
        fr.tx_burst(1'b1, 1'b0, 4, 160, 320);
        repeat (16) @(posedge hclk);
        chk(32'(np[0] - p0), 32'h2);
        chk(32'(np[1] - n0), 32'h2);
        fr.rx_burst(1'b1, 1'b0, 70);
        repeat (8) @(negedge hclk);
        chk(32'(pin11_out), 32'h1);
        ahb(1'b0, OFS_STATUS, 32'h0, rd);
        chk((rd >> EV_AIS) & 32'h1, 32'h1);
    endtask

    task automatic t_host;
        logic [31:0] rd;
        logic [7:0] rb;
        int o0;
        do_reset(1'b1, 1'b1);
        ahb(1'b0, OFS_MODE, 32'h0, rd);
        chk(rd & 32'h7, 32'(MODE_HOST));
        repeat (60) @(negedge hclk);
        chk(32'(pin23_oe_n), 32'h1);
        ahb(1'b1, OFS_MASK, 32'h1 << EV_STALL, rd);
        repeat (3) @(negedge hclk);
        chk({30'h0, pin23_oe_n, pin23_in}, 32'h0);
        o0 = oe_cnt;
        fr.serial(1'b0, 8'h68, rb);
        chk(32'(oe_cnt - o0), 32'h0);
        ahb(1'b0, OFS_CFG, 32'h0, rd);
        chk(rd, 32'h0d);
        fr.serial(1'b1, 8'h00, rb);
        chk({24'h0, rb & 8'h07}, 32'h1);
        chk(32'(oe_cnt > o0), 32'h1);
        @(negedge hclk);
        chk(32'(pin25_oe_n), 32'h1);
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        mode_above_low = 1'b0;
        mode_above_high = 1'b0;
        edge_select = 1'b0;
        host = 1'b0;
        t_hw;
        t_tx;
        t_irq;
        t_rx;
        t_ext;
        t_host;
        close_out;
    end

    // Far beyond the expected run of well under a tenth of this span.
    initial
    begin
        #2000000;
        n_mismatch++;
        close_out;
    end
endmodule // lim_mode_pin_ctrl_bench
